/* File: rtl/rpc_core.sv */
// Repeater port core: repeats one port's receive stream to the others.
// Assumes MII pins are asynchronous and receive clocks run freely.
`timescale 1ns/1ps
`default_nettype none
module rpc_core
  import rpc_pkg::*;
#(
  parameter int NPORT      = 11,
  parameter int JAB_LIMIT  = rpc_pkg::JAB_BITS,
  parameter int IDLE_LIMIT = rpc_pkg::IDLE_BITS
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  // MII receive pins, one per port
  input  wire logic [NPORT-1:0]      mii_rx_clk,
  input  wire logic [NPORT-1:0]      per_port_carrier_sense,
  input  wire logic [NPORT-1:0]      mii_rx_dv,
  input  wire logic [NPORT-1:0]      mii_rx_er,
  input  wire logic [NPORT-1:0][3:0] mii_rxd,
  input  wire logic [NPORT-1:0]      phy_is_tx,
  // MII transmit side
  output logic [NPORT-1:0]           receive_direction_enable,
  output logic [NPORT-1:0]           mii_tx_en,
  output logic [3:0]                 mii_txd,
  output logic                       mii_tx_er,
  // Status
  output logic                       collision_report_out,
  output logic [NPORT-1:0]           partition_status,
  output logic [NPORT-1:0]           jabber_status,
  output logic [NPORT-1:0]           isolate_status
);
  import rpc_pkg::*;

  // ****************************************************************
  // Parameter checks and derived limits
  // ****************************************************************
  // port count and timer limit bounds
  generate
    if (NPORT < 2 || NPORT > NPORT_MAX || JAB_LIMIT > 131000 ||
        IDLE_LIMIT + IPG_BITS > 131000) begin : g_chk
      $error("rpc_core parameters out of range");
    end
  endgenerate

  localparam logic [16:0] JAB_TH  = 17'(JAB_LIMIT);
  localparam logic [16:0] FC_TH   = 17'(FC_BITS);
  localparam logic [16:0] VC_TH   = 17'(VC_BITS);
  localparam logic [16:0] IDLE_TH = 17'(IDLE_LIMIT + IPG_BITS);
  localparam logic [9:0]  REC_TH  = 10'(RECON_BITS);
  localparam logic [6:0]  COL_TH  = 7'(COLL_LIMIT);
  localparam int          LW      = $clog2(FIFO_DEPTH) + 1;

  function automatic logic [3:0] ones(input logic [NPORT-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int k = 0; k < NPORT; k++) begin
      c = c + 4'(v[k]);
    end
    return c;
  endfunction

  function automatic logic [3:0] first(input logic [NPORT-1:0] v);
    logic [3:0] x;
    x = 4'h0;
    for (int k = NPORT - 1; k >= 0; k--) begin
      if (v[k]) begin
        x = 4'(k);
      end
    end
    return x;
  endfunction

  function automatic logic [16:0] add4(input logic [16:0] v);
    return (v > 17'h1FFF0) ? v : 17'(v + 17'(BITS_PER_NIB));
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [SB_W-1:0] s1;
    logic [SB_W-1:0] s2;
    logic [SB_W-1:0] s3;
    logic [SB_W-1:0] flt;
    logic            fc_seen;
    logic            dv_seen;
    logic            last_false;
    logic            part;
    logic            jab;
    logic            iso;
    logic [6:0]      coll_cnt;
    logic [16:0]     rx_bits;
    logic [16:0]     idle_bits;
    logic [9:0]      tx_bits;
  } rpc_port_type;

  typedef struct packed {
    rpc_port_type [NPORT-1:0] p;
    logic [NPORT-1:0]         rx_en;
    logic [NPORT-1:0]         tx_en;
    logic [3:0]               txd;
    logic                     txer;
    logic                     jam;
    logic                     busy;
    logic                     drain;
    logic [3:0]               src;
  } rpc_state_type;

  rpc_state_type    st_r;
  rpc_state_type    st_nxt;
  logic [1:0]       rst_sync_r;
  logic             rst_n;
  logic [NPORT-1:0] stb;
  logic [NPORT-1:0] crs;
  logic [NPORT-1:0] is_tx;
  logic [NPORT-1:0] blocked;
  logic [NPORT-1:0] car;
  logic [NPORT-1:0] act;
  logic [3:0]       ncar;
  logic             jam_hit;
  logic             jam_rise;
  logic             sstb;
  logic             f_flush;
  logic             f_in_valid;
  logic             f_in_ready;
  rpc_nib_type      f_in_data;
  logic             f_out_valid;
  logic             f_out_ready;
  rpc_nib_type      f_out_data;
  logic [LW-1:0]    f_level;

  // Release of the asynchronous reset is synchronised
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {1'b1, rst_sync_r[1]};
    end
  end
  assign rst_n = rst_sync_r[0];

  rpc_fifo #(
    .W     ($bits(rpc_nib_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (f_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NPORT; i++) begin
      st_nxt.p[i].s1 = {phy_is_tx[i], mii_rxd[i], mii_rx_er[i], mii_rx_dv[i],
                        per_port_carrier_sense[i], mii_rx_clk[i]};
      st_nxt.p[i].s2 = st_r.p[i].s1;
      st_nxt.p[i].s3 = st_r.p[i].s2;
      for (int b = 0; b < SB_W; b++) begin
        if (st_r.p[i].s2[b] == st_r.p[i].s3[b]) begin
          st_nxt.p[i].flt[b] = st_r.p[i].s3[b];
        end
      end
      // Falling receive clock: data has been stable for half a period
      stb[i]     = st_r.p[i].flt[SB_CLK] && !st_nxt.p[i].flt[SB_CLK];
      crs[i]     = st_r.p[i].flt[SB_CRS];
      is_tx[i]   = st_r.p[i].flt[SB_TX];
      blocked[i] = st_r.p[i].jab || st_r.p[i].iso;
    end
    car      = crs & ~blocked;
    act      = car & ~{NPORT{1'b0}};
    for (int i = 0; i < NPORT; i++) begin
      act[i] = car[i] && !st_r.p[i].part;
    end
    ncar     = ones(act);
    jam_hit  = (ncar >= 4'h2);
    jam_rise = jam_hit && !st_r.jam;
    sstb     = stb[st_r.src];

    for (int i = 0; i < NPORT; i++) begin
      if (!crs[i]) begin
        st_nxt.p[i].jab = 1'b0;
      end
      if (stb[i] && crs[i]) begin
        st_nxt.p[i].rx_bits   = add4(st_r.p[i].rx_bits);
        st_nxt.p[i].idle_bits = 17'h0;
        // false carrier code from the PHY
        if (st_r.p[i].flt[SB_ER] && !st_r.p[i].flt[SB_DV] &&
            st_r.p[i].flt[SB_D +: 4] == MII_FALSE_CAR) begin
          st_nxt.p[i].fc_seen = 1'b1;
          if (st_nxt.p[i].rx_bits > FC_TH) begin
            st_nxt.p[i].iso = 1'b1;
          end
        end
        if (st_r.p[i].flt[SB_DV]) begin
          st_nxt.p[i].dv_seen = 1'b1;
        end
        if (st_nxt.p[i].rx_bits > JAB_TH) begin
          st_nxt.p[i].jab = 1'b1;
        end
      end else if (stb[i]) begin
        st_nxt.p[i].idle_bits = add4(st_r.p[i].idle_bits);
        st_nxt.p[i].rx_bits   = 17'h0;
        st_nxt.p[i].fc_seen   = 1'b0;
        st_nxt.p[i].dv_seen   = 1'b0;
        if (st_r.p[i].rx_bits != 17'h0) begin
          if (st_r.p[i].fc_seen) begin
            // second false carrier in a row
            if (st_r.p[i].last_false) begin
              st_nxt.p[i].iso = 1'b1;
            end
            st_nxt.p[i].last_false = 1'b1;
          end else if (st_r.p[i].dv_seen) begin
            st_nxt.p[i].last_false = 1'b0;
            if (st_r.p[i].rx_bits >= VC_TH) begin
              st_nxt.p[i].iso = 1'b0;
            end
          end
        end
        if (st_nxt.p[i].idle_bits > IDLE_TH) begin
          st_nxt.p[i].iso = 1'b0;
        end
      end
      if (!is_tx[i]) begin
        st_nxt.p[i].iso        = 1'b0;
        st_nxt.p[i].last_false = 1'b0;
      end
      if (jam_rise && car[i]) begin
        if (st_r.p[i].coll_cnt != 7'h7F) begin
          st_nxt.p[i].coll_cnt = st_r.p[i].coll_cnt + 7'h1;
        end
        if (st_nxt.p[i].coll_cnt >= COL_TH) begin
          st_nxt.p[i].part = 1'b1;
        end
        st_nxt.p[i].tx_bits = 10'h0;
      end else if (st_r.p[i].part && st_r.tx_en[i] && sstb) begin
        if (crs[i]) begin
          st_nxt.p[i].tx_bits = 10'h0;
        end else if (st_r.p[i].tx_bits + 10'(BITS_PER_NIB) > REC_TH) begin
          st_nxt.p[i].part     = 1'b0;
          st_nxt.p[i].coll_cnt = 7'h0;
          st_nxt.p[i].tx_bits  = 10'h0;
        end else begin
          st_nxt.p[i].tx_bits = st_r.p[i].tx_bits + 10'(BITS_PER_NIB);
        end
      end
    end

    st_nxt.rx_en = act;
    st_nxt.tx_en = st_r.tx_en & ~blocked;
    st_nxt.jam   = jam_hit;
    f_flush      = 1'b0;
    f_in_valid   = 1'b0;
    // Error flag sits just below the nibble in the pin vector
    f_in_data.er = st_r.p[st_r.src].flt[SB_ER];
    f_in_data.d  = st_r.p[st_r.src].flt[SB_D +: 4];
    f_out_ready  = 1'b0;
    if (jam_hit) begin
      // jam from detection while collision lasts
      st_nxt.tx_en = ~blocked;
      st_nxt.txd   = JAM_NIB;
      st_nxt.txer  = 1'b0;
      st_nxt.busy  = 1'b0;
      st_nxt.drain = 1'b0;
      f_flush      = 1'b1;
    end else if (st_r.jam) begin
      // Leftover frame data is stale after a collision
      st_nxt.tx_en = '0;
      f_flush      = 1'b1;
    end else if (!st_r.busy) begin
      st_nxt.tx_en = '0;
      if (ncar == 4'h1) begin
        st_nxt.busy = 1'b1;
        st_nxt.src  = first(act);
      end
    end else begin
      // Push only after the receive enable has been raised
      f_in_valid = sstb && st_r.rx_en[st_r.src] &&
                   (st_r.p[st_r.src].flt[SB_DV] || st_r.p[st_r.src].flt[SB_ER]);
      // drain starts at a fixed fill or when the source carrier ends
      if (!st_r.drain && (f_level >= LW'(LAT_NIBS) || (sstb && !act[st_r.src]))) begin
        st_nxt.drain = 1'b1;
      end
      if (st_r.drain && sstb) begin
        if (f_out_valid) begin
          f_out_ready  = 1'b1;
          st_nxt.tx_en = ~(NPORT'(1) << st_r.src) & ~blocked;
          st_nxt.txd   = f_out_data.d;
          st_nxt.txer  = f_out_data.er;
        end else begin
          st_nxt.tx_en = '0;
          if (!act[st_r.src]) begin
            st_nxt.busy  = 1'b0;
            st_nxt.drain = 1'b0;
            // clean frame breaks the collision run
            st_nxt.p[st_r.src].coll_cnt = 7'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < NPORT; i++) begin
      partition_status[i] = st_r.p[i].part;
      jabber_status[i]    = st_r.p[i].jab;
      isolate_status[i]   = st_r.p[i].iso;
    end
  end
  assign receive_direction_enable = st_r.rx_en;
  assign mii_tx_en                = st_r.tx_en;
  assign mii_txd                  = st_r.txd;
  assign mii_tx_er                = st_r.txer;
  assign collision_report_out     = st_r.jam;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Watched ports need at least seven ports
  if (NPORT > 6) begin : g_ast
  AST_RECEIVE_DIRECTION_ENABLE_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (f_in_valid && f_in_ready) |-> $past(receive_direction_enable[st_r.src]))
    else $error("nibble pushed without receive enable");
  AST_JAM_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ncar >= 4'h2) |=> (collision_report_out && mii_txd == JAM_NIB))
    else $error("collision did not start jam");
  AST_JAM_END: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.jam && ncar < 4'h2) |=> (!collision_report_out && mii_tx_en == '0))
    else $error("jam did not end with collision");
  AST_PART_ENTER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.p[2].coll_cnt == 7'(COLL_LIMIT - 1) && jam_rise && car[2])
      |=> partition_status[2])
    else $error("port not partitioned at collision limit");
  AST_PART_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    partition_status[2] |=> !receive_direction_enable[2])
    else $error("partitioned port still receiving");
  AST_JAB_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    jabber_status[4] |=> (!receive_direction_enable[4] && !mii_tx_en[4]))
    else $error("jabber port not blocked");
  AST_JAB_CLEAR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (jabber_status[4] && !crs[4]) |=> !jabber_status[4])
    else $error("jabber held without carrier");
  AST_ISO_BLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    isolate_status[5] |=> (!receive_direction_enable[5] && !mii_tx_en[5]))
    else $error("isolated port not blocked");
  AST_T4_IGNORE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !is_tx[6] |=> !isolate_status[6])
    else $error("T4 port isolated");
  AST_TXER_MARK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (f_out_ready && f_out_valid && f_out_data.er && !jam_hit) |=> (mii_tx_er && |mii_tx_en))
    else $error("receive error not repeated");
  end

endmodule
`default_nettype wire

/* File: pkg/rpc_pkg.sv */
// Shared constants and carriers for the repeater port core.
// Assumes one system clock; all link signals arrive as pins.
package rpc_pkg;

  // ****************************************************************
  // Port count and buffering
  // ****************************************************************
  localparam int NPORT_MAX  = 11;
  localparam int FIFO_DEPTH = 32;
  localparam int LAT_NIBS   = 4;

  // ****************************************************************
  // Timers in bit times, bits per nibble and the collision limit
  // ****************************************************************
  localparam int BITS_PER_NIB = 4;
  localparam int COLL_LIMIT   = 64;
  localparam int RECON_BITS   = 512;
  localparam int JAB_BITS     = 65536;
  localparam int FC_BITS      = 480;
  localparam int IDLE_BITS    = 33792;
  localparam int IPG_BITS     = 80;
  localparam int VC_BITS      = 480;

  // ****************************************************************
  // Code groups and nibble values
  // ****************************************************************
  localparam logic [4:0] CG_IDLE       = 5'h1F;
  localparam logic [4:0] CG_SSD_J      = 5'h18;
  localparam logic [4:0] CG_SSD_K      = 5'h11;
  localparam logic [4:0] CG_ESD_T      = 5'h0D;
  localparam logic [4:0] CG_ESD_R      = 5'h07;
  localparam logic [3:0] MII_SSD_NIB   = 4'h5;
  localparam logic [3:0] MII_FALSE_CAR = 4'hE;
  localparam logic [3:0] JAM_NIB       = MII_SSD_NIB;

  // ****************************************************************
  // Layout of the synchronised pin vector
  // ****************************************************************
  localparam int SB_CLK = 0;
  localparam int SB_CRS = 1;
  localparam int SB_DV  = 2;
  localparam int SB_ER  = 3;
  localparam int SB_D   = 4;
  localparam int SB_TX  = 8;
  localparam int SB_W   = 9;

  typedef struct packed {
    logic       er;
    logic [3:0] d;
  } rpc_nib_type;

endpackage

/* File: rtl/rpc_fifo.sv */
// Nibble FIFO with valid/ready on both sides, flush and fill level.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module rpc_fifo #(
  parameter int W     = 5,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       flush,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH):0]          level
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("rpc_fifo depth must be a power of two");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } rpc_fifo_type;

  rpc_fifo_type st_r;
  rpc_fifo_type st_nxt;

  always_comb begin
    level     = st_r.wp - st_r.rp;
    in_ready  = (level != (AW+1)'(DEPTH));
    out_valid = (st_r.wp != st_r.rp);
    out_data  = st_r.mem[st_r.rp[AW-1:0]];
    st_nxt    = st_r;
    if (flush) begin
      st_nxt.rp = st_r.wp;
    end else begin
      if (in_valid && in_ready) begin
        st_nxt.mem[st_r.wp[AW-1:0]] = in_data;
        st_nxt.wp = st_r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
        st_nxt.rp = st_r.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

/* File: verification/rpc_phy_model.sv */
// Receive-side PHY model for one port of the repeater core.
// Assumes the bench shapes each nibble through set, carrier, frame, fc.
`timescale 1ns/1ps
`default_nettype none
module rpc_phy_model #(
  parameter int PH = 3
) (
  output logic       rxc,
  output logic       crs,
  output logic       dv,
  output logic       er,
  output logic [3:0] d
);
  logic       c_n, v_n, e_n, drv;
  logic [3:0] d_n;
  initial begin
    {rxc, crs, dv, er, d, c_n, v_n, e_n, drv, d_n} = '0;
    #(PH);
    forever #40 rxc = ~rxc;
  end
  // Undriven data flips so stale nibbles never look valid
  always @(posedge rxc) begin
    crs <= c_n;
    dv  <= v_n;
    er  <= e_n;
    d   <= drv ? d_n : ~d;
  end
  task automatic set(input logic c, v, e, input logic [3:0] n, input logic w);
    @(negedge rxc);
    {c_n, v_n, e_n, d_n, drv} = {c, v, e, n, w};
  endtask
  task automatic carrier(input logic c);
    set(c, 1'b0, 1'b0, 4'h0, 1'b0);
  endtask
  task automatic frame(input int n, input int ep);
    for (int i = 0; i < n; i++) set(1'b1, 1'b1, i == ep, i[3:0] ^ 4'hA, 1'b1);
    carrier(1'b0);
  endtask
  task automatic fc();
    repeat (2) set(1'b1, 1'b0, 1'b1, 4'hE, 1'b1);
    repeat (3) carrier(1'b0);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Self-checking bench for the repeater core with eleven PHY models.
// Assumes shortened jabber and idle limits; receive clocks run freely.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rpc_pkg::*;
  localparam int NP = 11;
  logic               clk_sys, reset_n, tx_er, coll;
  logic [NP-1:0]      is_tx, rx_en, tx_en, part_st, jab_st, iso_st;
  logic [3:0]         txd;
  wire  [NP-1:0]      rxc, crs, dv, er;
  wire  [NP-1:0][3:0] rxd;
  int                 n_mismatch, checks;
  logic [4:0]         q[$];

  // ****************************************************************
  // Design and partners
  // ****************************************************************
  rpc_core #(.NPORT(NP), .JAB_LIMIT(600), .IDLE_LIMIT(200)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .mii_rx_clk(rxc),
    .per_port_carrier_sense(crs), .mii_rx_dv(dv), .mii_rx_er(er),
    .mii_rxd(rxd), .phy_is_tx(is_tx), .receive_direction_enable(rx_en),
    .mii_tx_en(tx_en), .mii_txd(txd), .mii_tx_er(tx_er),
    .collision_report_out(coll), .partition_status(part_st),
    .jabber_status(jab_st), .isolate_status(iso_st));
  for (genvar g = 0; g < NP; g++) begin : gp
    rpc_phy_model u (.rxc(rxc[g]), .crs(crs[g]), .dv(dv[g]), .er(er[g]), .d(rxd[g]));
  end

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  function automatic logic pick(input int k, input int i);
    case (k)
      0: return rx_en[i];
      1: return part_st[i];
      2: return jab_st[i];
      3: return iso_st[i];
      default: return coll;
    endcase
  endfunction
  // Bounded wait on one status bit; running out ends the run
  task automatic wt(input string nm, input int k, input int i, input logic w, input int nb);
    int n;
    for (n = 0; n < nb && pick(k, i) !== w; n++) @(negedge clk_sys);
    chk(nm, 16'(w), 16'(pick(k, i)));
    if (pick(k, i) !== w) end_of_test();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_repeat();
    q.delete();
    fork
      gp[0].u.frame(16, 5);
      for (int i = 0; i < 30; i++) begin
        @(negedge rxc[0]);
        #60;
        if (tx_en[1] === 1'b1) q.push_back({tx_er, txd});
        if (i == 10) chk("rx_en", 16'h0001, 16'(rx_en));
        if (i == 10) chk("tx_en", 16'h07FE, 16'(tx_en));
      end
    join
    chk("count", 16'h0010, 16'(q.size()));
    foreach (q[i]) chk("nibble", {11'h000, i == 5, i[3:0] ^ 4'hA}, 16'(q[i]));
  endtask
  task automatic t_coll();
    fork
      gp[0].u.carrier(1'b1);
      gp[1].u.carrier(1'b1);
    join
    wt("coll_on", 4, 0, 1'b1, 50);
    @(negedge clk_sys);
    chk("jam", {11'h000, 1'b0, JAM_NIB}, {11'h000, tx_er, txd});
    chk("jam_en", 16'h07FF, 16'(tx_en));
    gp[1].u.carrier(1'b0);
    wt("coll_off", 4, 0, 1'b0, 50);
    chk("jam_end", 16'h0000, 16'(tx_en));
    gp[0].u.carrier(1'b0);
    repeat (30) @(negedge clk_sys);
  endtask
  task automatic t_part();
    for (int n = 1; n <= COLL_LIMIT; n++) begin
      fork
        gp[2].u.carrier(1'b1);
        gp[3].u.carrier(1'b1);
      join
      wt("jam", 4, 0, 1'b1, 50);
      fork
        gp[2].u.carrier(1'b0);
        gp[3].u.carrier(1'b0);
      join
      wt("quiet", 4, 0, 1'b0, 50);
      repeat (10) @(negedge clk_sys);
      if (n == COLL_LIMIT - 1) chk("part63", 16'h0000, 16'(part_st));
    end
    wt("part", 1, 2, 1'b1, 20);
    chk("part_own", 16'h000C, 16'(part_st));
    gp[2].u.carrier(1'b1);
    repeat (20) @(negedge clk_sys);
    chk("part_rx", 16'h0000, 16'(rx_en));
    gp[2].u.carrier(1'b0);
    repeat (20) @(negedge clk_sys);
    fork
      gp[0].u.frame(140, -1);
      begin
        repeat (200) @(negedge clk_sys);
        chk("part_tx", 16'h07FE, 16'(tx_en));
      end
    join
    wt("recon", 1, 2, 1'b0, 100);
    chk("recon_all", 16'h0000, 16'(part_st));
  endtask
  task automatic t_jab();
    fork
      gp[4].u.frame(170, -1);
      begin
        repeat (140) @(negedge rxc[4]);
        chk("jab_early", 16'h0000, 16'(jab_st));
        repeat (20) @(negedge rxc[4]);
        chk("jab", 16'h0010, 16'(jab_st));
        chk("jab_cut", 16'h0000, 16'(rx_en | tx_en));
      end
    join
    wt("jab_clr", 2, 4, 1'b0, 100);
  endtask
  task automatic t_iso();
    gp[5].u.fc();
    gp[5].u.fc();
    wt("iso", 3, 5, 1'b1, 50);
    gp[5].u.carrier(1'b1);
    repeat (20) @(negedge clk_sys);
    chk("iso_rx", 16'h0000, 16'(rx_en));
    gp[5].u.carrier(1'b0);
    gp[6].u.fc();
    gp[6].u.fc();
    chk("t4_iso", 16'h0020, 16'(iso_st));
    repeat (300) @(negedge clk_sys);
    chk("iso_hold", 16'h0020, 16'(iso_st));
    wt("iso_clr", 3, 5, 1'b0, 1500);
    gp[5].u.fc();
    gp[5].u.fc();
    wt("iso_again", 3, 5, 1'b1, 50);
    @(posedge clk_sys);
    #1;
    is_tx = 11'h000;
    wt("t4_clr", 3, 5, 1'b0, 20);
    @(posedge clk_sys);
    #1;
    is_tx = 11'h7FF;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    n_mismatch = 0;
    checks = 0;
    reset_n = 1'b0;
    is_tx = 11'h7BF;
    repeat (2) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk("reset", 16'h0000, 16'(rx_en | tx_en | part_st | jab_st | iso_st));
    t_repeat();
    t_coll();
    t_part();
    t_jab();
    t_iso();
    end_of_test();
  end
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule
`default_nettype wire
